// ---- rcrb_link_model.sv ----
`timescale 1ns/1ns
// Baseband side of the three-wire control link.
module rcrb_link_model
(
    output logic ser_clk_out,
    output logic ser_data_out,
    output logic ser_latch_out
);
    // The link clock stands low between frames, as a real controller leaves it.
    initial
    begin
        ser_clk_out   = 1'b0;
        ser_data_out  = 1'b0;
        ser_latch_out = 1'b0;
    end

    // Shifts one 16-bit load, MSB first, then strobes it; half_ns sets the link pace.
    task automatic send(input logic [15:0] word, input int half_ns);
        for (int i = 15; i >= 0; i--)
        begin
            ser_data_out = word[i];
            #(half_ns);
            ser_clk_out = 1'b1;
            #(half_ns);
            ser_clk_out = 1'b0;
        end
        // A released data line shows the opposite level so stale bits are not mistaken.
        ser_data_out  = ~word[0];
        ser_latch_out = 1'b1;
        #40;
        ser_latch_out = 1'b0;
        #40;
    endtask
endmodule // rcrb_link_model

// ---- rcrb_pkg.sv ----
package rcrb_pkg;

    // Serial frame geometry: data field first, then the address field.
    localparam int WORD_W = 16;
    localparam int DATA_W = 14;
    localparam int ADDR_W = 2;
    localparam int CHAN_W = 12;
    localparam int DIV_W  = 13;

    // Register selection codes carried in the address field.
    localparam logic [1:0] ADDR_SYNTH   = 2'h0;
    localparam logic [1:0] ADDR_CHANNEL = 2'h1;
    localparam logic [1:0] ADDR_TEST    = 2'h2;
    localparam logic [1:0] ADDR_NONE    = 2'h3;

    // Reset contents of every register.
    localparam logic [13:0] DATA_RESET = 14'h0000;

    // Reference division ratios chosen by the divide-select bit.
    localparam logic [3:0] REF_DIV_LOW  = 4'h6;
    localparam logic [3:0] REF_DIV_HIGH = 4'hC;

    // Intermediate frequency offset in MHz and the channel step in MHz.
    localparam real OFFSET_MHZ = 1.024;
    localparam real STEP_MHZ   = 0.512;
    // Offset expressed in channel steps.
    localparam logic [12:0] OFFSET_STEPS = 13'(int'(OFFSET_MHZ / STEP_MHZ));

    // Test selector codes.
    localparam logic [2:0] TEST_NORMAL   = 3'h0;
    localparam logic [2:0] DTEST_AGC     = 3'h1;
    localparam logic [2:0] DTEST_MAINDIV = 3'h2;
    localparam logic [2:0] DTEST_REFDIV  = 3'h3;

    // Synthesizer configuration register, reserved bits on top.
    typedef struct packed {
        logic [7:0] reserved;
        logic       tx_power_bit;
        logic       tx_carrier_test;
        logic       lo_shift_select;
        logic       rx_loop_closed;
        logic       ref_divide_select;
        logic       pump_polarity;
    } rcrb_synth_t;

    // Channel register.
    typedef struct packed {
        logic [1:0]  reserved;
        logic [11:0] channel_field;
    } rcrb_channel_t;

    // Test register.
    typedef struct packed {
        logic [7:0] reserved;
        logic [2:0] digital_test_select;
        logic [2:0] analog_test_select;
    } rcrb_test_t;

    // One serial load as it sits in the shift register.
    typedef struct packed {
        logic [13:0] data;
        logic [1:0]  addr;
    } rcrb_frame_t;

endpackage

// ---- rcrb_top.sv ----
`timescale 1ns/1ns
module rcrb_top
    import rcrb_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    input  wire logic              ser_clk_in,
    input  wire logic              ser_data_in,
    input  wire logic              ser_latch_in,
    input  wire logic              receive_enable_in,
    input  wire logic              tx_data_in,
    input  wire logic              demod_data_in,
    input  wire logic              agc_state_in,
    input  wire logic              main_div_in,
    input  wire logic              ref_div_in,
    output logic                   pump_polarity_out,
    output logic [3:0]             ref_divide_ratio_out,
    output logic                   loop_closed_out,
    output logic                   modulate_out,
    output logic [DIV_W-1:0]       synth_divide_out,
    output logic [CHAN_W-1:0]      channel_field_out,
    output logic [2:0]             analog_test_select_out,
    output logic                   analog_test_active_out,
    output logic                   power_ctrl_output_out,
    output logic                   power_ctrl_output_oe_out,
    output logic                   tx_mod_data_out,
    output logic                   rx_data_out
);

    // Link domain: the shift register runs on the serial clock only.
    rcrb_frame_t shift_q;
    rcrb_frame_t next_shift;

    // Each rising serial edge pushes one bit in at the bottom, so the address lands last.
    always_comb
    begin
        next_shift = rcrb_frame_t'({shift_q[WORD_W-2:0], ser_data_in});
    end

    always_ff @(posedge ser_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            shift_q <= rcrb_frame_t'(16'h0000);
        else
            shift_q <= next_shift;
    end

    // Core domain: latch strobe and receive enable both pass two flip-flops.
    logic latch_meta;
    logic latch_sync;
    logic latch_prev;
    logic rxe_meta;
    logic rxe_sync;
    logic rxe_prev;
    logic next_latch_meta;
    logic next_latch_sync;
    logic next_latch_prev;
    logic next_rxe_meta;
    logic next_rxe_sync;
    logic next_rxe_prev;

    always_comb
    begin
        next_latch_meta = ser_latch_in;
        next_latch_sync = latch_meta;
        next_latch_prev = latch_sync;
        next_rxe_meta   = receive_enable_in;
        next_rxe_sync   = rxe_meta;
        next_rxe_prev   = rxe_sync;
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            latch_meta <= 1'b0;
            latch_sync <= 1'b0;
            latch_prev <= 1'b0;
            rxe_meta   <= 1'b0;
            rxe_sync   <= 1'b0;
            rxe_prev   <= 1'b0;
        end
        else
        begin
            latch_meta <= next_latch_meta;
            latch_sync <= next_latch_sync;
            latch_prev <= next_latch_prev;
            rxe_meta   <= next_rxe_meta;
            rxe_sync   <= next_rxe_sync;
            rxe_prev   <= next_rxe_prev;
        end
    end

    // Edge events seen in the core domain.
    logic load_pulse;
    logic rxe_fall;
    assign load_pulse = latch_sync & ~latch_prev;
    assign rxe_fall   = ~rxe_sync & rxe_prev;

    // The serial clock must stand still while the latch strobe is high, so the
    // shift register is quiet when the synchronised strobe edge samples it.
    rcrb_frame_t   frame;
    assign frame = shift_q;

    rcrb_synth_t   synth_q;
    rcrb_channel_t chan_q;
    rcrb_test_t    test_q;
    logic          power_q;
    rcrb_synth_t   next_synth;
    rcrb_channel_t next_chan;
    rcrb_test_t    next_test;
    logic          next_power;

    // Address decode; the unused code changes nothing.
    always_comb
    begin
        next_synth = synth_q;
        next_chan  = chan_q;
        next_test  = test_q;
        if (load_pulse)
        begin
            case (frame.addr)
                ADDR_SYNTH:   next_synth = rcrb_synth_t'(frame.data);
                ADDR_CHANNEL: next_chan  = rcrb_channel_t'(frame.data);
                ADDR_TEST:    next_test  = rcrb_test_t'(frame.data);
                default:      next_synth = synth_q;
            endcase
        end
        // The written power bit waits for the start of the next transmit slot.
        next_power = rxe_fall ? synth_q.tx_power_bit : power_q;
    end

    // All storage clears at reset, reserved bits included.
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            synth_q <= rcrb_synth_t'(DATA_RESET);
            chan_q  <= rcrb_channel_t'(DATA_RESET);
            test_q  <= rcrb_test_t'(DATA_RESET);
            power_q <= 1'b0;
        end
        else
        begin
            synth_q <= next_synth;
            chan_q  <= next_chan;
            test_q  <= next_test;
            power_q <= next_power;
        end
    end

    // Synthesizer controls follow the configuration fields directly.
    logic analog_test;
    logic offset_here;
    assign analog_test = (test_q.analog_test_select != TEST_NORMAL);
    // The offset belongs to receive unless the shift bit moves it to transmit.
    assign offset_here = rxe_sync ? ~synth_q.lo_shift_select : synth_q.lo_shift_select;

    always_comb
    begin
        pump_polarity_out      = synth_q.pump_polarity;
        ref_divide_ratio_out   = synth_q.ref_divide_select ? REF_DIV_HIGH : REF_DIV_LOW;
        loop_closed_out        = rxe_sync ? synth_q.rx_loop_closed
                                          : synth_q.tx_carrier_test;
        modulate_out           = ~rxe_sync & ~synth_q.tx_carrier_test;
        channel_field_out      = chan_q.channel_field;
        synth_divide_out       = {1'b0, chan_q.channel_field}
                                 + (offset_here ? OFFSET_STEPS : 13'h0000);
        analog_test_select_out = test_q.analog_test_select;
        analog_test_active_out = analog_test;
    end

    // Open-drain power pin: driven low only when set and not lent to test.
    assign power_ctrl_output_out    = 1'b0;
    assign power_ctrl_output_oe_out = power_q & ~analog_test;

    // Transmit data is not retimed, so chip edges follow the input directly.
    assign tx_mod_data_out = tx_data_in;

    // Receive output is delivered unclocked; test codes swap in internal signals.
    always_comb
    begin
        case (test_q.digital_test_select)
            TEST_NORMAL:   rx_data_out = demod_data_in;
            DTEST_AGC:     rx_data_out = agc_state_in;
            DTEST_MAINDIV: rx_data_out = main_div_in;
            DTEST_REFDIV:  rx_data_out = ref_div_in;
            default:       rx_data_out = 1'b0;
        endcase
    end

    // Helper for checks: set once any register load has been taken.
    logic loaded_q;
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            loaded_q <= 1'b0;
        else
            loaded_q <= loaded_q | (load_pulse & (frame.addr != ADDR_NONE));
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    a_reset_all_clear: assert property (
        !loaded_q |-> (synth_q == '0 && chan_q == '0 && test_q == '0 && !power_q))
        else $error("Registers not clear before the first load.");

    a_synth_load_value: assert property (
        load_pulse && frame.addr == ADDR_SYNTH |=> synth_q == $past(frame.data))
        else $error("Configuration load did not take the frame data.");

    a_chan_load_value: assert property (
        load_pulse && frame.addr == ADDR_CHANNEL
        |=> channel_field_out == $past(frame.data[CHAN_W-1:0]))
        else $error("Channel field did not follow the load.");

    a_ignore_addr_three: assert property (
        load_pulse && frame.addr == ADDR_NONE
        |=> $stable(synth_q) && $stable(chan_q) && $stable(test_q))
        else $error("Load with unused address changed a register.");

    a_power_hold_state: assert property (
        !rxe_fall |=> $stable(power_q))
        else $error("Power state moved without a receive-enable fall.");

    a_power_take_bit: assert property (
        rxe_fall |=> power_q == $past(synth_q.tx_power_bit))
        else $error("Power state missed the bit at the slot start.");

    a_rx_offset_add: assert property (
        rxe_sync && !synth_q.lo_shift_select
        |-> synth_divide_out == {1'b0, chan_q.channel_field} + OFFSET_STEPS)
        else $error("Receive divide lacks the offset.");

    a_tx_no_offset: assert property (
        !rxe_sync && !synth_q.lo_shift_select
        |-> synth_divide_out == {1'b0, chan_q.channel_field})
        else $error("Transmit divide carries an offset.");

    a_ref_ratio: assert property (
        ref_divide_ratio_out == (synth_q.ref_divide_select ? REF_DIV_HIGH : REF_DIV_LOW))
        else $error("Reference ratio disagrees with the select bit.");

    a_test_frees_pin: assert property (
        test_q.analog_test_select != TEST_NORMAL |-> !power_ctrl_output_oe_out)
        else $error("Power pin driven during analog test.");

    a_dout_normal: assert property (
        test_q.digital_test_select == TEST_NORMAL |-> rx_data_out == demod_data_in)
        else $error("Receive output not demodulated data in normal mode.");

    a_tx_passthrough: assert property (
        tx_mod_data_out == tx_data_in)
        else $error("Transmit data was altered.");

    a_carrier_test_mode: assert property (
        !rxe_sync && synth_q.tx_carrier_test |-> (loop_closed_out && !modulate_out))
        else $error("Carrier test mode still modulates or leaves the loop open.");

    a_rx_loop_follow: assert property (
        rxe_sync |-> ((loop_closed_out == synth_q.rx_loop_closed) && !modulate_out))
        else $error("Receive loop state does not follow its bit.");

    a_tx_shift_offset: assert property (
        !rxe_sync && synth_q.lo_shift_select
        |-> synth_divide_out == {1'b0, chan_q.channel_field} + OFFSET_STEPS)
        else $error("Shifted transmit divide lacks the offset.");

    a_dout_agc_code: assert property (
        test_q.digital_test_select == DTEST_AGC |-> rx_data_out == agc_state_in)
        else $error("Receive output not the gain state under its test code.");

    a_pin_drive_low: assert property (
        power_ctrl_output_oe_out |-> (!power_ctrl_output_out && power_q))
        else $error("Power pin driven without the latched bit or not low.");

    c_synth_load: cover property (load_pulse && frame.addr == ADDR_SYNTH);
    c_chan_load: cover property (load_pulse && frame.addr == ADDR_CHANNEL);
    c_power_slot: cover property (rxe_fall && synth_q.tx_power_bit);
    c_test_mode: cover property (load_pulse && frame.addr == ADDR_TEST);
    c_ignored_load: cover property (load_pulse && frame.addr == ADDR_NONE);

endmodule // rcrb_top

// ---- test_radio_control_register_bank.sv ----
`timescale 1ns/1ns
module test_radio_control_register_bank;
    import rcrb_pkg::*;
    logic              clock_in, rst_n_in, ser_clk_in, ser_data_in, ser_latch_in;
    logic              receive_enable_in, tx_data_in, demod_data_in, agc_state_in;
    logic              main_div_in, ref_div_in, pump_polarity_out, loop_closed_out;
    logic              modulate_out, analog_test_active_out, power_ctrl_output_out;
    logic              power_ctrl_output_oe_out, tx_mod_data_out, rx_data_out;
    logic [3:0]        ref_divide_ratio_out;
    logic [DIV_W-1:0]  synth_divide_out;
    logic [CHAN_W-1:0] channel_field_out;
    logic [2:0]        analog_test_select_out;
    logic [5:0]        cfg;
    int                n_mismatch;
    int                check_count;

    rcrb_top uut (.clock_in, .rst_n_in, .ser_clk_in, .ser_data_in, .ser_latch_in,
        .receive_enable_in, .tx_data_in, .demod_data_in, .agc_state_in, .main_div_in,
        .ref_div_in, .pump_polarity_out, .ref_divide_ratio_out, .loop_closed_out,
        .modulate_out, .synth_divide_out, .channel_field_out, .analog_test_select_out,
        .analog_test_active_out, .power_ctrl_output_out, .power_ctrl_output_oe_out,
        .tx_mod_data_out, .rx_data_out);
    rcrb_link_model lnk (.ser_clk_out(ser_clk_in), .ser_data_out(ser_data_in),
        .ser_latch_out(ser_latch_in));

    // Core clock at 250 MHz.
    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(negedge clock_in);
    endtask

    // The load is complete well inside the strobe time, so outputs are settled on return.
    task automatic load(input logic [1:0] addr, input logic [13:0] data);
        lnk.send({data, addr}, 80);
        wait_cycles(2);
    endtask

    // Receive enable passes a synchronizer, so allow it eight cycles to take effect.
    task automatic set_rx(input logic v);
        receive_enable_in = v;
        wait_cycles(8);
    endtask

    // A hang is cut off well beyond the expected run of about 125 us.
    initial
    begin
        #300000;
        n_mismatch++;
        give_verdict();
    end

    // Main sequence.
    initial
    begin
        n_mismatch = 0;
        check_count = 0;
        rst_n_in = 1'b0;
        {receive_enable_in, tx_data_in, agc_state_in, main_div_in, ref_div_in} = 5'h00;
        demod_data_in = 1'b1;
        wait_cycles(8);
        rst_n_in = 1'b1;
        wait_cycles(2);
        check("pump rst", 16'(pump_polarity_out), 16'h0);
        check("ratio rst", 16'(ref_divide_ratio_out), 16'h6);
        check("chan rst", 16'(channel_field_out), 16'h0);
        check("asel rst", 16'(analog_test_select_out), 16'h0);
        check("oe rst", 16'(power_ctrl_output_oe_out), 16'h0);
        check("rx rst", 16'(rx_data_out), 16'h1);
        $display("test reset done");

        load(ADDR_CHANNEL, 14'h0FFD);
        check("chan", 16'(channel_field_out), 16'h0FFD);
        for (int c = 0; c < 32; c++)
        begin
            cfg = 6'(c);
            load(ADDR_SYNTH, {8'h00, cfg});
            check("pump", 16'(pump_polarity_out), 16'(cfg[0]));
            check("ratio", 16'(ref_divide_ratio_out), cfg[1] ? 16'hC : 16'h6);
            for (int r = 0; r < 2; r++)
            begin
                set_rx(r[0]);
                check("loop", 16'(loop_closed_out), 16'(r[0] ? cfg[2] : cfg[4]));
                check("mod", 16'(modulate_out), 16'(!r[0] && !cfg[4]));
                check("div", 16'(synth_divide_out), (r[0] ^ cfg[3]) ? 16'h0FFF : 16'h0FFD);
            end
        end
        $display("test synth config done");

        // The power pin moves only on a receive-enable fall, and test mode frees it.
        set_rx(1'b1);
        load(ADDR_SYNTH, 14'h0020);
        check("oe held", 16'(power_ctrl_output_oe_out), 16'h0);
        set_rx(1'b0);
        check("oe on", 16'(power_ctrl_output_oe_out), 16'h1);
        check("pin", 16'(power_ctrl_output_out), 16'h0);
        load(ADDR_SYNTH, 14'h0000);
        check("oe kept", 16'(power_ctrl_output_oe_out), 16'h1);
        load(ADDR_TEST, 14'h0005);
        check("atest", 16'(analog_test_active_out), 16'h1);
        check("asel", 16'(analog_test_select_out), 16'h5);
        check("oe freed", 16'(power_ctrl_output_oe_out), 16'h0);
        load(ADDR_TEST, 14'h0000);
        check("oe back", 16'(power_ctrl_output_oe_out), 16'h1);
        set_rx(1'b1);
        set_rx(1'b0);
        check("oe off", 16'(power_ctrl_output_oe_out), 16'h0);
        $display("test power pin done");

        // A load to the unused address must leave every register alone.
        load(ADDR_NONE, 14'h3FFF);
        check("ign chan", 16'(channel_field_out), 16'h0FFD);
        check("ign pump", 16'(pump_polarity_out), 16'h0);
        check("ign asel", 16'(analog_test_select_out), 16'h0);
        $display("test unused address done");

        // Every digital selector code against every input pattern.
        for (int d = 0; d < 8; d++)
        begin
            load(ADDR_TEST, 14'(d << 3));
            for (int p = 0; p < 16; p++)
            begin
                @(negedge clock_in);
                {ref_div_in, main_div_in, agc_state_in, demod_data_in} = 4'(p);
                tx_data_in = p[3];
                #1;
                check("rx data", 16'(rx_data_out), (d < 4) ? 16'(p[d]) : 16'h0);
                check("tx data", 16'(tx_mod_data_out), 16'(p[3]));
            end
        end
        $display("test data paths done");
        give_verdict();
    end
endmodule // test_radio_control_register_bank
